// ===== design/tpt_apb.sv
`default_nettype none
`include "tpt_defs.svh"

module tpt_apb (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // register side
  tpt_if.slv               regs
);
  import tpt_pkg::*;

  tpt_bus_st_t state;
  logic [9:0]  idx;
  logic        hit;
  logic [1:0]  tmr;
  logic        take;

  ////////////////////////////////////////////////////////////////////
  // decode
  always_comb begin
    idx = paddr[11:2];
    hit = 1'b0;
    tmr = 2'h0;
    if (paddr[1:0] == 2'h0 && !idx[0]) begin
      if (idx >= `TPT_IDX_T0_COUNT && idx <= `TPT_IDX_T0_MODE) begin
        hit = 1'b1;
      end else if (idx >= `TPT_IDX_T1_COUNT
                   && idx <= `TPT_IDX_T1_MODE) begin
        hit = 1'b1;
        tmr = 2'h1;
      end else if (idx >= `TPT_IDX_T2_COUNT && idx <= `TPT_IDX_T2_MODE
                   && idx != `TPT_IDX_T2_GAP) begin
        hit = 1'b1;
        tmr = 2'h2;
      end
    end
  end

  assign regs.tmr   = tmr;
  assign regs.sel   = tpt_reg_t'(idx[2:1]);
  assign regs.wdata = pwdata[15:0];
  // write lands on the edge where the master sees pready
  assign regs.wr    = ce && state == TPT_BUS_ACK && pwrite && hit;
  assign take       = state == TPT_BUS_IDLE && psel && penable;

  ////////////////////////////////////////////////////////////////////
  // one wait state on every access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= TPT_BUS_IDLE;
    end else if (ce) begin
      case (state)
        TPT_BUS_IDLE: if (take) state <= TPT_BUS_ACK;
        TPT_BUS_ACK:  state <= TPT_BUS_IDLE;
        default:      state <= TPT_BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= take;
      pslverr <= take && !hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      if (take && hit && !pwrite) prdata <= {16'h0000, regs.rdata};
      else if (take) prdata <= 32'h0000_0000;
    end
  end
endmodule

`default_nettype wire

// ===== design/tpt_defs.svh
`ifndef TPT_DEFS_SVH
`define TPT_DEFS_SVH

// register indices; byte address is four times the index
`define TPT_IDX_T0_COUNT 10'h050
`define TPT_IDX_T0_LIMA  10'h052
`define TPT_IDX_T0_LIMB  10'h054
`define TPT_IDX_T0_MODE  10'h056
`define TPT_IDX_T1_COUNT 10'h058
`define TPT_IDX_T1_LIMA  10'h05A
`define TPT_IDX_T1_LIMB  10'h05C
`define TPT_IDX_T1_MODE  10'h05E
`define TPT_IDX_T2_COUNT 10'h060
`define TPT_IDX_T2_LIMA  10'h062
`define TPT_IDX_T2_GAP   10'h064
`define TPT_IDX_T2_MODE  10'h066

// mode/control field positions
`define TPT_BIT_EN    15
`define TPT_BIT_INH   14
`define TPT_BIT_INT   13
`define TPT_BIT_RIU   12
`define TPT_BIT_MC    5
`define TPT_BIT_RTG   4
`define TPT_BIT_PRE   3
`define TPT_BIT_EXT   2
`define TPT_BIT_ALT   1
`define TPT_BIT_FREE_RUNNING  0

// reset values
`define TPT_RST_COUNT 16'h0000
`define TPT_RST_LIMIT 16'h0000

// timers are serviced once per this many clocks
`define TPT_SVC_DIV   4

`endif

// ===== design/tpt_if.sv
`default_nettype none

interface tpt_if;
  import tpt_pkg::*;

  logic        wr;
  logic [1:0]  tmr;
  tpt_reg_t    sel;
  logic [15:0] wdata;
  logic [15:0] rdata;

  modport slv (
    output wr,
    output tmr,
    output sel,
    output wdata,
    input  rdata
  );

  modport core (
    input  wr,
    input  tmr,
    input  sel,
    input  wdata,
    output rdata
  );
endinterface

`default_nettype wire

// ===== design/tpt_pkg.sv
`default_nettype none

package tpt_pkg;

  typedef enum logic [1:0] {
    TPT_BUS_IDLE = 2'b01,
    TPT_BUS_ACK  = 2'b10
  } tpt_bus_st_t;

  typedef enum logic [1:0] {
    TPT_REG_COUNT = 2'b00,
    TPT_REG_LIMA  = 2'b01,
    TPT_REG_LIMB  = 2'b10,
    TPT_REG_MODE  = 2'b11
  } tpt_reg_t;

endpackage

`default_nettype wire

// ===== design/tpt_sync.sv
`default_nettype none

module tpt_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q    <= '0;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

`default_nettype wire

// ===== design/tpt_top.sv
// Notes on behaviour
// - count registers are readable and writable at any time, running or not
// - count increments by one on each qualifying timer event
// - count matching the active limit clears to zero in that same clock
// - timers 0 and 1 have limits A and B; timer 2 only A
// - single-limit mode pulses the output low one clock, one clock after hit; here two clocks after hit
// - dual-limit mode drives output low while B active, high while A active
// - dual-limit clear compares the active limit, A or B; set toggles A/B on each hit
// - free-running keeps counting after a limit; otherwise counting stops
// - not free-running with dual limit: count A, reset, count B, halt
// - timers update only on every fourth clock
// - output responds to an input change within six clocks; here up to seven
// - count and limit registers are sixteen bits
// - every register access takes one wait state
// - each timer can raise an interrupt request at terminal count
// - timers 0 and 1 have input and output pins, ext clock, retrigger
// - timer 2 has no pins; its terminal count prescales and requests dma
// - mode/control register reads back the programmed mode
// - outside clock counts input rising edges; else pin is a control input
// - internal clock: level gates counting, or rising edge restarts at zero
// - limit-reached flag set on every limit hit; only software clears it
// - reset clears enables and selects limit A, so output pins go high
//
// Design decision made here: register access over APB.
`default_nettype none
`include "tpt_defs.svh"

module tpt_top (
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // timer pins
  input  wire logic [1:0]  tmr_in,
  output logic      [1:0]  tmr_out,
  // event requests
  output logic      [2:0]  tmr_irq,
  output logic             dma_req
);
  import tpt_pkg::*;

  localparam int NT = 3;

  tpt_if regs ();

  logic [1:0]  pin_s;
  logic [2:0]  pin_all;
  logic [1:0]  phase;
  logic        tick;
  logic        pre_pend;

  // per-timer state, indexed by timer number
  logic [15:0] cnt      [NT];
  logic [15:0] lima     [NT];
  logic [15:0] limb     [NT];
  logic [15:0] mode_rd  [NT];
  logic        en       [NT];
  logic        int_en   [NT];
  logic        active_limit_indicator      [NT];
  logic        mc       [NT];
  logic        edge_restart_select      [NT];
  logic        pre      [NT];
  logic        outside_clock_select      [NT];
  logic        dual_limit_select      [NT];
  logic        free_running     [NT];
  logic        armed    [NT];
  logic        pin_prev [NT];
  logic        tc_q     [NT];
  logic        out_q    [NT];
  logic        irq_q    [NT];
  logic        hit      [NT];
  logic        cnt_ev   [NT];
  logic        restart  [NT];

  ////////////////////////////////////////////////////////////////////
  // pins and bus

  // pins are asynchronous to pclk
  // two stages cost two clocks of the six-clock response budget
  tpt_sync #(
    .W (2)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       (tmr_in),
    .q       (pin_s)
  );

  // timer 2 has no pin; its slot reads as low
  assign pin_all = {1'b0, pin_s};

  tpt_apb u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .regs    (regs)
  );

  ////////////////////////////////////////////////////////////////////
  // service slot: one timer update per four clocks
  // the phase runs from reset and ignores bus traffic, so the
  // slot never drifts when software reads or writes a timer

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 2'h0;
    end else if (ce) begin
      phase <= phase + 2'h1;
    end
  end

  assign tick = ce && phase == 2'(`TPT_SVC_DIV - 1);

  // timer 2 terminal count held until the next slot so that
  // timers 0 and 1 see it as a prescaled clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_pend <= 1'b0;
    end else if (ce) begin
      if (hit[2]) pre_pend <= 1'b1;
      else if (tick) pre_pend <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // timers

  for (genvar i = 0; i < NT; i++) begin : g_tmr
    localparam bit FULL = (i < 2);

    logic        sel_me;
    logic        wr_cnt;
    logic        wr_lima;
    logic        wr_limb;
    logic        wr_mode;
    logic        edge_up;
    logic        base;
    logic        gate;
    logic [15:0] inc;
    logic [15:0] lim;
    logic [15:0] wd;

    assign sel_me  = regs.wr && regs.tmr == 2'(i);
    assign wr_cnt  = sel_me && regs.sel == TPT_REG_COUNT;
    assign wr_lima = sel_me && regs.sel == TPT_REG_LIMA;
    assign wr_limb = sel_me && regs.sel == TPT_REG_LIMB && FULL;
    assign wr_mode = sel_me && regs.sel == TPT_REG_MODE;
    assign wd      = regs.wdata;

    // edges judged against the pin level at the previous slot;
    // relies on inputs changing no faster than the slot rate
    assign edge_up = pin_all[i] && !pin_prev[i];
    assign lim     = active_limit_indicator[i] ? limb[i] : lima[i];
    assign inc     = cnt[i] + 16'h0001;
    assign base    = pre[i] ? pre_pend : 1'b1;
    assign gate    = !FULL || (edge_restart_select[i] ? armed[i] : pin_all[i]);

    assign restart[i] = tick && en[i] && !outside_clock_select[i] && edge_restart_select[i]
                        && edge_up;
    assign cnt_ev[i]  = tick && en[i] && !restart[i]
                        && (outside_clock_select[i] ? edge_up : (base && gate));
    // only equality counts; a limit below the count wraps first
    assign hit[i]     = cnt_ev[i] && inc == lim;

    // count: software write wins over the timer
    // a limit of zero is met only after the count wraps: 65536 steps
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt[i] <= `TPT_RST_COUNT;
      end else if (ce) begin
        if (wr_cnt) cnt[i] <= wd;
        else if (restart[i]) cnt[i] <= 16'h0000;
        else if (hit[i]) cnt[i] <= 16'h0000;
        else if (cnt_ev[i]) cnt[i] <= inc;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        lima[i] <= `TPT_RST_LIMIT;
        limb[i] <= `TPT_RST_LIMIT;
      end else if (ce) begin
        if (wr_lima) lima[i] <= wd;
        if (wr_limb) limb[i] <= wd;
      end
    end

    // stored mode fields; timer 2 keeps its pin options at zero
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        int_en[i] <= 1'b0;
        free_running[i]   <= 1'b0;
        edge_restart_select[i]    <= 1'b0;
        pre[i]    <= 1'b0;
        outside_clock_select[i]    <= 1'b0;
        dual_limit_select[i]    <= 1'b0;
      end else if (ce && wr_mode) begin
        int_en[i] <= wd[`TPT_BIT_INT];
        free_running[i]   <= wd[`TPT_BIT_FREE_RUNNING];
        edge_restart_select[i]    <= FULL && wd[`TPT_BIT_RTG];
        pre[i]    <= FULL && wd[`TPT_BIT_PRE];
        outside_clock_select[i]    <= FULL && wd[`TPT_BIT_EXT];
        dual_limit_select[i]    <= FULL && wd[`TPT_BIT_ALT];
      end
    end

    // software changes enable only when the inhibit-override bit is written one
    // a write without inhibit-override leaves a running timer's enable alone
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        en[i] <= 1'b0;
      end else if (ce) begin
        if (wr_mode && wd[`TPT_BIT_INH]) begin
          en[i] <= wd[`TPT_BIT_EN];
        end else if (hit[i] && !free_running[i] && (!dual_limit_select[i] || active_limit_indicator[i])) begin
          en[i] <= 1'b0;
        end
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        active_limit_indicator[i] <= 1'b0;
      end else if (ce) begin
        if (!dual_limit_select[i]) active_limit_indicator[i] <= 1'b0;
        else if (hit[i]) active_limit_indicator[i] <= !active_limit_indicator[i];
      end
    end

    // a hit in the same cycle as a clearing write keeps the flag
    // so software never loses a terminal count it has not yet seen
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mc[i] <= 1'b0;
      end else if (ce) begin
        if (hit[i]) mc[i] <= 1'b1;
        else if (wr_mode && !wd[`TPT_BIT_MC]) mc[i] <= 1'b0;
      end
    end

    // retrigger mode waits for the first rising edge
    // an edge seen while disabled does not arm it
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        armed[i] <= 1'b0;
      end else if (ce) begin
        if (!en[i] || !edge_restart_select[i]) armed[i] <= 1'b0;
        else if (restart[i]) armed[i] <= 1'b1;
      end
    end

    // tracked while disabled too, so a stale edge never fires on enable
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_prev[i] <= 1'b0;
      end else if (tick) begin
        pin_prev[i] <= pin_all[i];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tc_q[i]  <= 1'b0;
        irq_q[i] <= 1'b0;
      end else if (ce) begin
        tc_q[i]  <= hit[i];
        irq_q[i] <= hit[i] && int_en[i];
      end
    end

    // output pin idles high
    // driven from the registered hit so the pin never glitches; the
    // extra clock makes worst-case pin-to-pin latency seven clocks
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        out_q[i] <= 1'b1;
      end else if (ce) begin
        if (dual_limit_select[i]) out_q[i] <= !active_limit_indicator[i];
        else out_q[i] <= !tc_q[i];
      end
    end

    always_comb begin
      mode_rd[i] = 16'h0000;
      mode_rd[i][`TPT_BIT_EN]   = en[i];
      mode_rd[i][`TPT_BIT_INT]  = int_en[i];
      mode_rd[i][`TPT_BIT_RIU]  = active_limit_indicator[i];
      mode_rd[i][`TPT_BIT_MC]   = mc[i];
      mode_rd[i][`TPT_BIT_RTG]  = edge_restart_select[i];
      mode_rd[i][`TPT_BIT_PRE]  = pre[i];
      mode_rd[i][`TPT_BIT_EXT]  = outside_clock_select[i];
      mode_rd[i][`TPT_BIT_ALT]  = dual_limit_select[i];
      mode_rd[i][`TPT_BIT_FREE_RUNNING] = free_running[i];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read mux and outputs

  // index 3 names no timer; the guard keeps the array read in range
  always_comb begin
    regs.rdata = 16'h0000;
    if (regs.tmr != 2'h3) begin
      case (regs.sel)
        TPT_REG_COUNT: regs.rdata = cnt[regs.tmr];
        TPT_REG_LIMA:  regs.rdata = lima[regs.tmr];
        TPT_REG_LIMB:  regs.rdata = limb[regs.tmr];
        TPT_REG_MODE:  regs.rdata = mode_rd[regs.tmr];
        default:       regs.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_req <= 1'b0;
    end else if (ce) begin
      // one-clock strobe per timer 2 terminal count
      dma_req <= hit[2];
    end
  end

  assign tmr_out = {out_q[1], out_q[0]};
  assign tmr_irq = {irq_q[2], irq_q[1], irq_q[0]};
endmodule

`default_nettype wire

// ===== dv/tpt_monitor.sv
`default_nettype none

module tpt_monitor (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins and requests
  input wire logic [1:0]  tmr_in,
  input wire logic [1:0]  tmr_out,
  input wire logic [2:0]  tmr_irq,
  input wire logic        dma_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////
  wait_state_a: assert property (psel && !penable ##1 psel && penable
    |-> !pready ##1 pready) else $error("missing single wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  irq_space_a: assert property (tmr_irq[0] |=> !tmr_irq[0] [*3])
    else $error("timer 0 request closer than a slot");
  dma_space_a: assert property (dma_req |=> !dma_req [*3])
    else $error("dma request closer than a slot");
  irq_dma_a: assert property (tmr_irq[2] |-> dma_req)
    else $error("timer 2 request without dma request");
  reset_out_a: assert property ($rose(presetn)
    |-> tmr_out == 2'b11 && tmr_irq == 3'b000)
    else $error("pins not idle after reset");

  ////////////////////////////////////////////////////////////////////////
  irq_seen_c: cover property (tmr_irq[0]);
  dma_seen_c: cover property (dma_req);
  err_seen_c: cover property (pslverr);
endmodule

bind tpt_top tpt_monitor u_mon (.pclk, .presetn, .ce, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tmr_in,
  .tmr_out, .tmr_irq, .dma_req);

`default_nettype wire

// ===== dv/tpt_pin_src.sv
`default_nettype none

module tpt_pin_src (
  // clock
  input  wire logic       pclk,
  // control from bench
  input  wire logic       lvl0,
  input  wire logic       go,
  input  wire logic [3:0] n,
  // pins
  output logic      [1:0] tmr_in,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] left = 4'h0;
  logic [2:0] ph = 3'h0;

  // one edge per 8 clocks keeps well inside the quarter-rate limit
  always @(posedge pclk) begin
    if (go) begin
      left <= n;
      ph <= 3'h0;
    end else if (left != 4'h0) begin
      ph <= ph + 3'h1;
      if (ph == 3'h7)
        left <= left - 4'h1;
    end
  end
  assign busy = left != 4'h0;
  // pin 0 is a gate level, pin 1 a burst of rising edges
  assign tmr_in = {busy & ph[2], lvl0};
endmodule

`default_nettype wire

// ===== dv/tpt_tb.sv
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        lvl0 = 1'b0;
  logic        go = 1'b0;
  logic [3:0]  n = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  tmr_in;
  logic [1:0]  tmr_out;
  logic [2:0]  tmr_irq;
  logic        dma_req;
  logic        busy;
  int          bad_count = 0;
  int          tests_run = 0;

  tpt_top DUT (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tmr_in, .tmr_out,
    .tmr_irq, .dma_req);
  tpt_pin_src u_src (.pclk, .lvl0, .go, .n, .tmr_in, .busy);

  initial forever #20 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////
  task finish_test;
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // upper half of write data is junk on purpose: it must be ignored
  task bus(input logic w, input logic [11:0] a, input logic [15:0] d,
           output logic [32:0] r);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'hA5A5, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (k == 20) begin
      bad_count++;
      finish_test;
    end
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [15:0] d);
    logic [32:0] r;
    bus(1'b1, a, d, r);
  endtask

  task rd(input logic [11:0] a, input logic [32:0] e);
    logic [32:0] r;
    bus(1'b0, a, 16'h0000, r);
    chk(r, e);
  endtask

  // checks run before the edge's updates land, so they see sampled values
  task wt(input int s, output int k);
    for (k = 0; k < 400; k++) begin
      if (s == 0 && tmr_out[0] === 1'b0)
        break;
      if (s == 1 && tmr_out[0] === 1'b1)
        break;
      if (s == 2 && dma_req === 1'b1)
        break;
      if (s == 3 && busy === 1'b0)
        break;
      if (s == 4 && tmr_irq[1] === 1'b1)
        break;
      if (s == 5 && tmr_irq[0] === 1'b1)
        break;
      @(posedge pclk);
    end
    if (k == 400) begin
      bad_count++;
      finish_test;
    end
  endtask

  task burst(input logic [3:0] c);
    int k;
    n <= c;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    wt(3, k);
    // allow for the input pipeline latency
    repeat (6) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task t_reset;
    logic [11:0] map [11] = '{12'h140, 12'h148, 12'h150, 12'h158, 12'h160,
      12'h168, 12'h170, 12'h178, 12'h180, 12'h188, 12'h198};
    chk({31'h0, tmr_out}, 33'h0_0000_0003);
    foreach (map[i])
      rd(map[i], 33'h0_0000_0000);
    rd(12'h190, 33'h1_0000_0000);
    rd(12'h141, 33'h1_0000_0000);
  endtask

  task t_regs;
    wr(12'h140, 16'hFFFF);
    rd(12'h140, 33'h0_0000_FFFF);
    wr(12'h148, 16'h8001);
    rd(12'h148, 33'h0_0000_8001);
  endtask

  task t_single;
    int k;
    wr(12'h140, 16'h0000);
    wr(12'h148, 16'h0003);
    wr(12'h158, 16'hE000);
    repeat (20) @(posedge pclk);
    rd(12'h140, 33'h0_0000_0000);
    lvl0 <= 1'b1;
    wt(5, k);
    // pin falls one clock after the request pulse
    wt(0, k);
    chk(k, 1);
    wt(1, k);
    chk(k, 1);
    rd(12'h140, 33'h0_0000_0000);
    rd(12'h158, 33'h0_0000_2020);
    wr(12'h158, 16'h0000);
    rd(12'h158, 33'h0_0000_0000);
  endtask

  task t_dual;
    int k;
    wr(12'h148, 16'h0002);
    wr(12'h150, 16'h0003);
    wr(12'h158, 16'hC002);
    wt(0, k);
    wt(1, k);
    chk(k, 12);
    // long enough for several more slots had it kept running
    repeat (60) @(posedge pclk);
    rd(12'h140, 33'h0_0000_0000);
    rd(12'h158, 33'h0_0000_0022);
  endtask

  task t_ext;
    wr(12'h168, 16'h0064);
    burst(4'h3);
    wr(12'h178, 16'hC005);
    burst(4'h5);
    rd(12'h160, 33'h0_0000_0005);
  endtask

  task t_tmr2;
    int k;
    // timer 0 on the prescaled clock must stand still while timer 2 is off
    wr(12'h158, 16'hC008);
    repeat (40) @(posedge pclk);
    rd(12'h158, 33'h0_0000_8008);
    wr(12'h188, 16'h0002);
    wr(12'h198, 16'hE003);
    wt(2, k);
    chk({32'h0, tmr_irq[2]}, 33'h1);
    rd(12'h198, 33'h0_0000_A021);
    // two timer 2 hits bring timer 0 to its limit of 2, where it stops
    repeat (24) @(posedge pclk);
    rd(12'h158, 33'h0_0000_0028);
    wr(12'h198, 16'h4000);
  endtask

  task t_retrig;
    int k;
    wr(12'h168, 16'h0003);
    wr(12'h178, 16'hE010);
    // no count before the first rising edge
    repeat (20) @(posedge pclk);
    rd(12'h160, 33'h0_0000_0005);
    burst(4'h1);
    wt(4, k);
    @(posedge pclk);
    chk({32'h0, tmr_out[1]}, 33'h0);
    @(posedge pclk);
    chk({32'h0, tmr_out[1]}, 33'h1);
    rd(12'h160, 33'h0_0000_0000);
    rd(12'h178, 33'h0_0000_2030);
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_regs;
    t_single;
    t_dual;
    t_ext;
    t_retrig;
    t_tmr2;
    // a reset in mid-run must clear every register again
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    finish_test;
  end
endmodule

`default_nettype wire
